// ### bench/rcr_regs_props.sv
// Purpose: Assertions on the calendar register contents
// Assumes: Bound to rcr_regs, one clock domain
// Notes: Digit limits, reserved zeros, reset values and write timing
`timescale 1ns/1ps
module rcr_regs_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Observed outputs
	input wire logic s_axi_bvalid,
	input wire logic [7:0] time_seconds,
	input wire logic [7:0] time_minutes,
	input wire logic [7:0] time_hours,
	input wire logic [7:0] date_day_of_month,
	input wire logic [7:0] date_month,
	input wire logic [7:0] date_year,
	input wire logic twelve_hour_mode
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Tens limits cover the reserved bits above them too
	property p_sec_tens; time_seconds[7:4] <= 4'h5; endproperty
	a_sec_tens: assert property (p_sec_tens) else $error("seconds tens bad");
	property p_sec_units; time_seconds[3:0] <= 4'h9; endproperty
	a_sec_units: assert property (p_sec_units) else $error("seconds units bad");
	property p_min_tens; time_minutes[7:4] <= 4'h5; endproperty
	a_min_tens: assert property (p_min_tens) else $error("minute tens bad");
	property p_min_units; time_minutes[3:0] <= 4'h9; endproperty
	a_min_units: assert property (p_min_units) else $error("minute units bad");
	// Flag may lag a mode clear by one cycle
	property p_pm; !twelve_hour_mode && !$past(twelve_hour_mode) |-> !time_hours[7]; endproperty
	a_pm: assert property (p_pm) else $error("afternoon flag outside mode");
	property p_hour; time_hours[6:4] <= 3'h2 && time_hours[3:0] <= 4'h9; endproperty
	a_hour: assert property (p_hour) else $error("hour digits bad");
	property p_day; date_day_of_month[7:4] <= 4'h3 && date_day_of_month[3:0] <= 4'h9; endproperty
	a_day: assert property (p_day) else $error("day digits bad");
	property p_mon; date_month[7:4] <= 4'h1 && date_month[3:0] <= 4'h9; endproperty
	a_mon: assert property (p_mon) else $error("month digits bad");
	property p_year; date_year[7:4] <= 4'h9 && date_year[3:0] <= 4'h9; endproperty
	a_year: assert property (p_year) else $error("year digits bad");
	property p_rst; $rose(aresetn) |-> date_day_of_month == 8'h01 && date_month == 8'h01; endproperty
	a_rst: assert property (p_rst) else $error("date reset value bad");
	// Seconds only move with a write answer
	property p_wr; $changed(time_seconds) |-> s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("seconds changed without write");
endmodule
bind rcr_regs rcr_regs_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .time_seconds(time_seconds), .time_minutes(time_minutes),
	.time_hours(time_hours), .date_day_of_month(date_day_of_month), .date_month(date_month),
	.date_year(date_year), .twelve_hour_mode(twelve_hour_mode));

// ### bench/testbench.sv
// Purpose: Self-checking bench for the calendar time registers
// Assumes: Byte address is register index times four
// Notes: Out-of-range digits are expected to clamp at their limit
`timescale 1ns/1ps
module testbench;
	import rcr_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [5:0] awaddr = 6'h0;
	logic [5:0] araddr = 6'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, mode;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] secs, wday;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #12.5 aclk = ~aclk;
	rcr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.time_seconds(secs), .time_minutes(), .time_hours(), .date_day_of_month(), .date_month(),
		.date_year(), .date_weekday(wday), .twelve_hour_mode(mode));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Each channel is released at its own handshake edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aok = 0;
		bit wok = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(aok && wok)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'h1) aok = 1;
			if (wvalid && wready === 1'h1) wok = 1;
			if (aok) awvalid <= 1'h0;
			if (wok) wvalid <= 1'h0;
		end
		bready <= 1'h1;
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		d = rdata;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		logic [31:0] d;
		rd(a, RCR_RESP_OKAY, d);
		chk("rdata", {24'h0, e}, d);
	endtask
	task automatic wr_rd(input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
		wr(a, d, RCR_RESP_OKAY);
		rdc(a, e);
	endtask
	// Reset contents of every calendar register except the mode register
	task automatic t_reset;
		rdc(6'h00, 8'h00);
		rdc(6'h04, 8'h00);
		rdc(6'h08, 8'h00);
		rdc(6'h0c, 8'h01);
		rdc(6'h10, 8'h01);
		rdc(6'h14, 8'h00);
		rdc(6'h18, 8'h00);
	endtask
	// All-ones drops reserved bits and clamps digits; legal values kept
	task automatic t_limits;
		wr_rd(6'h00, 8'hff, 8'h59);
		wr_rd(6'h00, 8'h37, 8'h37);
		chk("seconds port", 32'h37, {24'h0, secs});
		wr_rd(6'h04, 8'hff, 8'h59);
		wr_rd(6'h04, 8'h48, 8'h48);
		wr_rd(6'h08, 8'hff, 8'h29);
		wr_rd(6'h0c, 8'hff, 8'h39);
		wr_rd(6'h10, 8'hff, 8'h19);
		wr_rd(6'h14, 8'hff, 8'h99);
		wr_rd(6'h14, 8'h47, 8'h47);
		wr_rd(6'h18, 8'hff, 8'h06);
		chk("weekday port", 32'h6, {24'h0, wday});
	endtask
	// Afternoon flag only lives in twelve-hour mode
	task automatic t_meridiem;
		wr_rd(6'h1c, 8'h01, 8'h01);
		chk("mode", 32'h1, {31'h0, mode});
		wr_rd(6'h08, 8'h91, 8'h91);
		wr_rd(6'h1c, 8'h00, 8'h00);
		chk("mode", 32'h0, {31'h0, mode});
		rdc(6'h08, 8'h11);
	endtask
	// Unmapped index answers with an error and reads zero
	task automatic t_unmapped;
		logic [31:0] d;
		wr(6'h20, 8'h55, RCR_RESP_SLVERR);
		rd(6'h24, RCR_RESP_SLVERR, d);
		chk("rdata", 32'h0, d);
	endtask
	task automatic do_reset;
		aresetn <= 1'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
	endtask
	initial begin
		do_reset();
		t_reset();
		t_limits();
		t_meridiem();
		t_unmapped();
		do_reset();
		t_reset();
		finish_test();
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			finish_test();
		end
	end
endmodule

// ### rtl/rcr_bcd_sat.sv
// Purpose: Clamp one BCD digit to its legal range
// Assumes: Digit widths up to four bits
// Notes: Out-of-range writes saturate at the upper limit
`timescale 1ns/1ps
module rcr_bcd_sat (
	// Digit in and limit
	input wire logic [3:0] digit_in,
	input wire logic [3:0] limit,
	// Clamped digit
	output logic [3:0] digit_out
);
	// Saturate rather than wrap, so software sees a sane value
	assign digit_out = (digit_in > limit) ? limit : digit_in;
endmodule

// ### rtl/rcr_pkg.sv
// Purpose: Constants for the calendar time register block
// Assumes: AXI4-Lite slave, 32-bit data, one register per word
// Notes: Register indices are byte offsets divided by four
//
// Operation
// - seconds tens in bits 6:4, 0..5, bit7 zero
// - seconds units in bits 3:0, 0..9, reset zero
// - minutes tens in bits 6:4, 0..5, bit7 zero
// - minutes units in bits 3:0, 0..9, reset zero
// - hours bit7 afternoon flag, twelve-hour only
// - hours tens in bits 5:4, 0..2, bit6 zero
// - hours units in bits 3:0, 0..9, reset zero
// - day tens 5:4, units 3:0, reset one
package rcr_pkg;
	localparam int RCR_ADDR_W = 6;
	// Register indices as printed
	localparam logic [3:0] RCR_IDX_SEC = 4'h0;
	localparam logic [3:0] RCR_IDX_MIN = 4'h1;
	localparam logic [3:0] RCR_IDX_HOUR = 4'h2;
	localparam logic [3:0] RCR_IDX_DAY = 4'h3;
	localparam logic [3:0] RCR_IDX_MON = 4'h4;
	localparam logic [3:0] RCR_IDX_YEAR = 4'h5;
	localparam logic [3:0] RCR_IDX_WDAY = 4'h6;
	localparam logic [3:0] RCR_IDX_MODE = 4'h7;
	localparam int RCR_NREG = 8;
	// Writable bit masks per register
	localparam logic [7:0] RCR_MASK_SEC = 8'h7f;
	localparam logic [7:0] RCR_MASK_MIN = 8'h7f;
	localparam logic [7:0] RCR_MASK_HOUR = 8'hbf;
	localparam logic [7:0] RCR_MASK_DAY = 8'h3f;
	localparam logic [7:0] RCR_MASK_MON = 8'h1f;
	localparam logic [7:0] RCR_MASK_YEAR = 8'hff;
	localparam logic [7:0] RCR_MASK_WDAY = 8'h07;
	localparam logic [7:0] RCR_MASK_MODE = 8'h01;
	// Reset values
	localparam logic [7:0] RCR_RST_SEC = 8'h00;
	localparam logic [7:0] RCR_RST_MIN = 8'h00;
	localparam logic [7:0] RCR_RST_HOUR = 8'h00;
	localparam logic [7:0] RCR_RST_DAY = 8'h01;
	localparam logic [7:0] RCR_RST_MON = 8'h01;
	localparam logic [7:0] RCR_RST_YEAR = 8'h00;
	localparam logic [7:0] RCR_RST_WDAY = 8'h00;
	localparam logic [7:0] RCR_RST_MODE = 8'h00;
	// Field positions
	localparam int RCR_AFTERNOON_BIT = 7;
	// Digit limits
	localparam logic [3:0] RCR_MAX_UNITS = 4'h9;
	localparam logic [3:0] RCR_MAX_SEC_TENS = 4'h5;
	localparam logic [3:0] RCR_MAX_HOUR_TENS = 4'h2;
	localparam logic [3:0] RCR_MAX_DAY_TENS = 4'h3;
	localparam logic [3:0] RCR_MAX_MON_TENS = 4'h1;
	localparam logic [3:0] RCR_MAX_WDAY = 4'h6;
	// AXI responses
	localparam logic [1:0] RCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCR_RESP_SLVERR = 2'h2;
endpackage

// ### rtl/rcr_regs.sv
// Purpose: Calendar time registers behind an AXI4-Lite slave
// Assumes: Single clock aclk, synchronous active-low reset
// Notes: Write answer one cycle after both channels taken and no earlier answer is pending
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module rcr_regs
	import rcr_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [RCR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel
	input wire logic [RCR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Current register contents for the update logic
	output logic [7:0] time_seconds,
	output logic [7:0] time_minutes,
	output logic [7:0] time_hours,
	output logic [7:0] date_day_of_month,
	output logic [7:0] date_month,
	output logic [7:0] date_year,
	output logic [7:0] date_weekday,
	output logic twelve_hour_mode
);
	// Register store
	logic [7:0] reg_q [RCR_NREG];
	logic aw_held_q;
	logic w_held_q;
	logic [RCR_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// Mask and reset lookup by index
	function automatic logic [7:0] wmask(input logic [3:0] idx);
		case (idx)
			RCR_IDX_SEC: wmask = RCR_MASK_SEC;
			RCR_IDX_MIN: wmask = RCR_MASK_MIN;
			RCR_IDX_HOUR: wmask = RCR_MASK_HOUR;
			RCR_IDX_DAY: wmask = RCR_MASK_DAY;
			RCR_IDX_MON: wmask = RCR_MASK_MON;
			RCR_IDX_YEAR: wmask = RCR_MASK_YEAR;
			RCR_IDX_WDAY: wmask = RCR_MASK_WDAY;
			RCR_IDX_MODE: wmask = RCR_MASK_MODE;
			default: wmask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rstval(input int idx);
		case (idx)
			1: rstval = RCR_RST_MIN;
			2: rstval = RCR_RST_HOUR;
			3: rstval = RCR_RST_DAY;
			4: rstval = RCR_RST_MON;
			5: rstval = RCR_RST_YEAR;
			6: rstval = RCR_RST_WDAY;
			7: rstval = RCR_RST_MODE;
			default: rstval = RCR_RST_SEC;
		endcase
	endfunction

	// Address decode for both channels
	function automatic logic mapped(input logic [RCR_ADDR_W-1:0] a);
		mapped = (a[RCR_ADDR_W-1:2] < 4'(RCR_NREG));
	endfunction

	// Write fires once both address and data are held and no answer is pending
	wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
	wire [3:0] wr_idx = awaddr_q[RCR_ADDR_W-1:2];
	wire wr_ok = mapped(awaddr_q);
	wire [7:0] wr_byte = wstrb_q[0] ? wdata_q[7:0] : reg_q[wr_idx[2:0]];
	wire [7:0] wr_masked = wr_byte & wmask(wr_idx);
	wire [3:0] rd_idx = s_axi_araddr[RCR_ADDR_W-1:2];
	wire rd_fire = s_axi_arvalid && s_axi_arready;

	// Clamp each BCD digit of the incoming byte
	wire [3:0] sat_lo;
	wire [3:0] sat_hi;
	wire [3:0] lim_lo = (wr_idx == RCR_IDX_WDAY) ? RCR_MAX_WDAY : RCR_MAX_UNITS;
	wire [3:0] lim_hi = (wr_idx == RCR_IDX_SEC || wr_idx == RCR_IDX_MIN) ? RCR_MAX_SEC_TENS :
		(wr_idx == RCR_IDX_HOUR) ? RCR_MAX_HOUR_TENS :
		(wr_idx == RCR_IDX_DAY) ? RCR_MAX_DAY_TENS :
		(wr_idx == RCR_IDX_MON) ? RCR_MAX_MON_TENS :
		RCR_MAX_UNITS;

	rcr_bcd_sat u_sat_lo (
		.digit_in(wr_masked[3:0]),
		.limit(lim_lo),
		.digit_out(sat_lo)
	);
	rcr_bcd_sat u_sat_hi (
		.digit_in({1'b0, wr_masked[6:4]} | {wr_masked[7] & (wr_idx == RCR_IDX_YEAR), 3'b000}),
		.limit(lim_hi),
		.digit_out(sat_hi)
	);

	// Afternoon flag survives only in twelve-hour mode
	wire pm_keep = reg_q[RCR_IDX_MODE[2:0]][0];
	wire [7:0] wr_final = (wr_idx == RCR_IDX_YEAR) ? {sat_hi, sat_lo} :
		(wr_idx == RCR_IDX_HOUR) ?
		{wr_masked[RCR_AFTERNOON_BIT] & pm_keep, 1'b0, sat_hi[1:0], sat_lo} :
		({1'b0, sat_hi[2:0], sat_lo} & wmask(wr_idx));

	// Register file; leaving twelve-hour mode clears the afternoon flag
	genvar gi;
	generate
		for (gi = 0; gi < RCR_NREG; gi++) begin : g_reg
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					reg_q[gi] <= rstval(gi);
				end else if (wr_fire && wr_ok && wr_idx == 4'(gi)) begin
					reg_q[gi] <= wr_final;
				end else if (gi == RCR_IDX_HOUR && !pm_keep) begin
					reg_q[gi] <= reg_q[gi] & ~8'h80;
				end
			end
		end
	endgenerate

	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RCR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? RCR_RESP_OKAY : RCR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read channel; unmapped reads answer zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RCR_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= mapped(s_axi_araddr) ? {24'h000000, reg_q[rd_idx[2:0]]} : 32'h0000_0000;
			rresp_q <= mapped(s_axi_araddr) ? RCR_RESP_OKAY : RCR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Ready terms; flops feed the ready outputs
	logic awready_q;
	logic wready_q;
	logic arready_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			awready_q <= !aw_held_q && !(s_axi_awvalid && awready_q);
			wready_q <= !w_held_q && !(s_axi_wvalid && wready_q);
			arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign time_seconds = reg_q[RCR_IDX_SEC[2:0]];
	assign time_minutes = reg_q[RCR_IDX_MIN[2:0]];
	assign time_hours = reg_q[RCR_IDX_HOUR[2:0]];
	assign date_day_of_month = reg_q[RCR_IDX_DAY[2:0]];
	assign date_month = reg_q[RCR_IDX_MON[2:0]];
	assign date_year = reg_q[RCR_IDX_YEAR[2:0]];
	assign date_weekday = reg_q[RCR_IDX_WDAY[2:0]];
	assign twelve_hour_mode = reg_q[RCR_IDX_MODE[2:0]][0];
endmodule
